// ---- cfg_map.svh ----
/*
  Offsets, bit positions, reset values and masks of the register bank.
  Assumes it is included by its bare name wherever the values are needed.
*/
`ifndef CFG_MAP_SVH
`define CFG_MAP_SVH

`define OFS_SOFT_RST      8'h01
`define OFS_FIRST_CFG     8'h03
`define OFS_SECOND_CFG    8'h04

`define SOFT_RST_RST      8'h00
`define FIRST_CFG_RST     8'hd2
`define SECOND_CFG_RST    8'h80

`define SOFT_RST_WMASK    8'h80
`define FIRST_CFG_WMASK   8'hbb
`define SECOND_CFG_WMASK  8'ha0
`define SECOND_CFG_WMASK2 8'h0c
`define FIRST_CFG_RSVD    8'h44

`define BIT_FULL_RST      1
`define BIT_LOGIC_RST     0
`define BIT_AUTO_PD       7
`define BIT_CRC_EN        7
`define BIT_AUTO_ACK      5
`define BIT_FILTER_EN     4
`define BIT_PASS_THRU     3
`define BIT_OSC_AUTO      1
`define BIT_EDGE_SEL      0
`define BIT_FAILSAFE      7
`define BIT_CRC_CLR       5
`define BIT_COMPAT_SRC    3
`define BIT_COMPAT_REG    2

`define I2C_BYTE_BITS     4'h8
`define BITS_ZERO         4'h0

`endif

// ---- cfg_pkg.sv ----
/*
  Types shared by the register bank and its two leaf modules.
  Assumes nothing of its surroundings.
*/
package cfg_pkg;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } wr_req_t;

  typedef struct packed {
    logic de;
    logic hs;
    logic vs;
  } video_t;

endpackage

// ---- i2c_slave_port.sv ----
/*
  Two-wire control bus slave: address match, register pointer, bursts.
  Assumes open-drain SCL/SDA pins and a read data mux answering rd_addr.
*/
`timescale 1ns/10ps
`include "cfg_map.svh"

module i2c_slave_port (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       clk_en,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic [6:0] dev_addr,
  input  wire logic [7:0] rd_data,
  output logic [7:0]      rd_addr,
  output logic            sda_oe,
  output cfg_pkg::wr_req_t wr_req
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_PTR, ST_WDAT, ST_ACK, ST_RDAT, ST_RACK
  } bus_st_t;

  bus_st_t          st_ff;
  bus_st_t          ack_next_ff;
  logic [1:0]       scl_sy_ff;
  logic [1:0]       sda_sy_ff;
  logic             scl_d_ff;
  logic             sda_d_ff;
  logic [7:0]       shift_ff;
  logic [3:0]       cnt_ff;
  logic [7:0]       ptr_ff;
  logic             drive_ff;
  logic             mack_ff;
  cfg_pkg::wr_req_t wr_ff;
  logic             scl_rise;
  logic             scl_fall;
  logic             start_det;
  logic             stop_det;
  logic             full;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus conditions
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_sy_ff <= 2'h3;
      sda_sy_ff <= 2'h3;
      scl_d_ff  <= 1'b1;
      sda_d_ff  <= 1'b1;
    end else if (clk_en) begin
      scl_sy_ff <= {scl_sy_ff[0], scl_in};
      sda_sy_ff <= {sda_sy_ff[0], sda_in};
      scl_d_ff  <= scl_sy_ff[1];
      sda_d_ff  <= sda_sy_ff[1];
    end
  end

  assign scl_rise  = scl_sy_ff[1] & ~scl_d_ff;
  assign scl_fall  = ~scl_sy_ff[1] & scl_d_ff;
  assign start_det = scl_sy_ff[1] & scl_d_ff & sda_d_ff & ~sda_sy_ff[1];
  assign stop_det  = scl_sy_ff[1] & scl_d_ff & ~sda_d_ff & sda_sy_ff[1];
  assign full      = (cnt_ff == `I2C_BYTE_BITS);

  //////////////////////////////////////////////////////////////////////////
  // Transaction sequencer
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff       <= ST_IDLE;
      ack_next_ff <= ST_IDLE;
      shift_ff    <= 8'h00;
      cnt_ff      <= `BITS_ZERO;
      ptr_ff      <= 8'h00;
      drive_ff    <= 1'b0;
      mack_ff     <= 1'b0;
      wr_ff       <= '0;
    end else if (clk_en) begin
      wr_ff.valid <= 1'b0;
      if (start_det) begin
        st_ff    <= ST_ADDR;
        cnt_ff   <= `BITS_ZERO;
        drive_ff <= 1'b0;
      end else if (stop_det) begin
        st_ff    <= ST_IDLE;
        drive_ff <= 1'b0;
      end else if (scl_rise) begin
        unique case (st_ff)
          ST_ADDR, ST_PTR, ST_WDAT: begin
            shift_ff <= {shift_ff[6:0], sda_sy_ff[1]};
            cnt_ff   <= cnt_ff + 4'h1;
          end
          ST_RDAT: begin
            shift_ff <= {shift_ff[6:0], 1'b0};
            cnt_ff   <= cnt_ff + 4'h1;
          end
          ST_RACK: mack_ff <= ~sda_sy_ff[1];
          ST_IDLE, ST_ACK: ;
        endcase
      end else if (scl_fall) begin
        unique case (st_ff)
          ST_ADDR: if (full) begin
            if (shift_ff[7:1] == dev_addr) begin
              drive_ff    <= 1'b1;
              st_ff       <= ST_ACK;
              ack_next_ff <= shift_ff[0] ? ST_RDAT : ST_PTR;
            end else begin
              st_ff <= ST_IDLE;
            end
          end
          ST_PTR: if (full) begin
            ptr_ff      <= shift_ff;
            drive_ff    <= 1'b1;
            st_ff       <= ST_ACK;
            ack_next_ff <= ST_WDAT;
          end
          ST_WDAT: if (full) begin
            wr_ff       <= '{valid: 1'b1, addr: ptr_ff, data: shift_ff};
            ptr_ff      <= ptr_ff + 8'h01;
            drive_ff    <= 1'b1;
            st_ff       <= ST_ACK;
            ack_next_ff <= ST_WDAT;
          end
          ST_ACK: begin
            cnt_ff <= `BITS_ZERO;
            st_ff  <= ack_next_ff;
            if (ack_next_ff == ST_RDAT) begin
              shift_ff <= rd_data;
              drive_ff <= ~rd_data[7];
            end else begin
              drive_ff <= 1'b0;
            end
          end
          ST_RDAT: if (full) begin
            drive_ff <= 1'b0;
            ptr_ff   <= ptr_ff + 8'h01;
            st_ff    <= ST_RACK;
          end else begin
            drive_ff <= ~shift_ff[7];
          end
          ST_RACK: if (mack_ff) begin
            cnt_ff   <= `BITS_ZERO;
            shift_ff <= rd_data;
            drive_ff <= ~rd_data[7];
            st_ff    <= ST_RDAT;
          end else begin
            st_ff <= ST_IDLE;
          end
          ST_IDLE: ;
        endcase
      end
    end
  end

  assign rd_addr = ptr_ff;
  assign sda_oe  = drive_ff;
  assign wr_req  = wr_ff;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  chk_stop_ends_txn: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    clk_en && stop_det && !start_det |=> st_ff == ST_IDLE && !drive_ff)
    else $error("stop did not end the transaction");

  chk_start_opens: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    clk_en && start_det |=> st_ff == ST_ADDR && cnt_ff == `BITS_ZERO)
    else $error("start did not open an address phase");

  cov_write_byte: cover property (
    @(posedge ref_clk) disable iff (!arst_n) wr_ff.valid);

endmodule

// ---- serializer_config_regs.sv ----
/*
  Reset and configuration register bank of a video serializer, reached
  over the two-wire control bus.
  Assumes the serializer datapath consumes the control outputs and that
  pix_tick, remote_target_hit and pass_all_en come from ref_clk logic.
*/
`timescale 1ns/10ps
`include "cfg_map.svh"

// What this block does
// - Reset bit 1 resets all logic and registers, then clears itself
// - Reset bit 0 resets logic but keeps registers, then clears itself
// - First config bit 7 enables back-channel CRC checker; resets to 0xd2
// - First config bit 5 acks remote writes at once; pass-all widens it
// - First config bit 4 rejects sync and enable pulses under two clocks
// - First config bit 1 switches to internal oscillator without pixel clock
// - First config bit 0 picks rising (1) or falling (0) sampling edge
// - Second config bit 5 holds CRC error counters cleared until written 0
// - Second config bit 3 picks register bit 2 or mode pin for compat
// - Under register control, bit 2 high enables legacy compatibility
// - Host reaches registers as two-wire bus slave, start to stop
module serializer_config_regs (
  input  wire logic            ref_clk,
  input  wire logic            arst_n,
  input  wire logic            clk_en,
  input  wire logic            scl_in,
  input  wire logic            sda_in,
  output logic                 sda_out,
  output logic                 sda_oe,
  input  wire logic [6:0]      dev_addr,
  input  wire logic            mode_sel_pin,
  input  wire logic            pclk_present,
  input  wire logic            pix_tick,
  input  wire cfg_pkg::video_t video_in,
  input  wire logic            remote_target_hit,
  input  wire logic            pass_all_en,
  output cfg_pkg::video_t      video_out,
  output logic                 crc_check_en,
  output logic                 remote_auto_ack,
  output logic                 pass_through_en,
  output logic                 remote_auto_pd,
  output logic                 osc_select,
  output logic                 pixel_edge_select,
  output logic                 failsafe_low,
  output logic                 crc_clear,
  output logic                 legacy_compat_mode,
  output logic                 logic_reset
);

  logic [7:0]       soft_rst_ff;
  logic [7:0]       first_cfg_ff;
  logic [7:0]       second_cfg_ff;
  logic [1:0]       rst_bits_ff;
  logic             logic_reset_ff;
  logic             osc_select_ff;
  logic             auto_ack_ff;
  logic             compat_ff;
  logic             sda_out_ff;
  logic [1:0]       mode_sy_ff;
  logic [1:0]       pclk_sy_ff;
  logic [7:0]       rd_addr;
  logic [7:0]       rd_data;
  logic             drive_low;
  cfg_pkg::wr_req_t wr_req;
  logic             wr_soft;
  logic             wr_first;
  logic             wr_second;

  //////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] data,
                                       input logic [7:0] mask);
    merge = (old & ~mask) | (data & mask);
  endfunction

  function automatic logic hit(input cfg_pkg::wr_req_t req,
                               input logic [7:0]       ofs);
    hit = req.valid && (req.addr == ofs);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Control bus slave
  i2c_slave_port u_bus (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .clk_en   (clk_en),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .dev_addr (dev_addr),
    .rd_data  (rd_data),
    .rd_addr  (rd_addr),
    .sda_oe   (drive_low),
    .wr_req   (wr_req)
  );

  assign wr_soft   = hit(wr_req, `OFS_SOFT_RST);
  assign wr_first  = hit(wr_req, `OFS_FIRST_CFG);
  assign wr_second = hit(wr_req, `OFS_SECOND_CFG);

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_sy_ff <= 2'h0;
      pclk_sy_ff <= 2'h3;
    end else if (clk_en) begin
      mode_sy_ff <= {mode_sy_ff[0], mode_sel_pin};
      pclk_sy_ff <= {pclk_sy_ff[0], pclk_present};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Self-clearing soft reset bits
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_bits_ff    <= 2'h0;
      logic_reset_ff <= 1'b0;
    end else if (clk_en) begin
      rst_bits_ff <= 2'h0;
      if (wr_soft) begin
        rst_bits_ff[1] <= wr_req.data[`BIT_FULL_RST];
        rst_bits_ff[0] <= wr_req.data[`BIT_LOGIC_RST];
      end
      logic_reset_ff <= |rst_bits_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register storage; logic-only reset leaves it alone
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      soft_rst_ff   <= `SOFT_RST_RST;
      first_cfg_ff  <= `FIRST_CFG_RST;
      second_cfg_ff <= `SECOND_CFG_RST;
    end else if (clk_en) begin
      if (rst_bits_ff[1]) begin
        soft_rst_ff   <= `SOFT_RST_RST;
        first_cfg_ff  <= `FIRST_CFG_RST;
        second_cfg_ff <= `SECOND_CFG_RST;
      end else begin
        if (wr_soft) begin
          soft_rst_ff <= merge(soft_rst_ff, wr_req.data, `SOFT_RST_WMASK);
        end
        if (wr_first) begin
          first_cfg_ff <= merge(first_cfg_ff, wr_req.data,
                                `FIRST_CFG_WMASK);
        end
        if (wr_second) begin
          second_cfg_ff <= merge(second_cfg_ff, wr_req.data,
                                 `SECOND_CFG_WMASK | `SECOND_CFG_WMASK2);
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped offsets read zero
  always_comb begin
    unique case (rd_addr)
      `OFS_SOFT_RST:   rd_data = {soft_rst_ff[7:2], rst_bits_ff};
      `OFS_FIRST_CFG:  rd_data = first_cfg_ff;
      `OFS_SECOND_CFG: rd_data = second_cfg_ff;
      default:         rd_data = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Oscillator fallback
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_select_ff <= 1'b0;
    end else if (clk_en) begin
      if (logic_reset_ff) begin
        osc_select_ff <= 1'b0;
      end else begin
        osc_select_ff <= first_cfg_ff[`BIT_OSC_AUTO] & ~pclk_sy_ff[1];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Remote write early acknowledge
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      auto_ack_ff <= 1'b0;
    end else if (clk_en) begin
      auto_ack_ff <= first_cfg_ff[`BIT_AUTO_ACK] &
                     (remote_target_hit | pass_all_en);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Legacy compatibility source
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      compat_ff <= 1'b0;
    end else if (clk_en) begin
      if (second_cfg_ff[`BIT_COMPAT_SRC]) begin
        compat_ff <= second_cfg_ff[`BIT_COMPAT_REG];
      end else begin
        compat_ff <= mode_sy_ff[1];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sync and enable glitch filter
  video_filter u_filter (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .clk_en   (clk_en),
    .sync_rst (logic_reset_ff),
    .pix_tick (pix_tick),
    .en       (first_cfg_ff[`BIT_FILTER_EN]),
    .raw      (video_in),
    .out      (video_out)
  );

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_out_ff <= 1'b0;
    end else if (clk_en) begin
      sda_out_ff <= 1'b0;
    end
  end

  assign sda_out            = sda_out_ff;
  assign sda_oe             = drive_low;
  assign crc_check_en       = first_cfg_ff[`BIT_CRC_EN];
  assign remote_auto_ack    = auto_ack_ff;
  assign pass_through_en    = first_cfg_ff[`BIT_PASS_THRU];
  assign remote_auto_pd     = soft_rst_ff[`BIT_AUTO_PD];
  assign osc_select         = osc_select_ff;
  assign pixel_edge_select  = first_cfg_ff[`BIT_EDGE_SEL];
  assign failsafe_low       = second_cfg_ff[`BIT_FAILSAFE];
  assign crc_clear          = second_cfg_ff[`BIT_CRC_CLR];
  assign legacy_compat_mode = compat_ff;
  assign logic_reset        = logic_reset_ff;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  chk_full_reset_regs: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    clk_en && wr_soft && wr_req.data[`BIT_FULL_RST] ##1 clk_en
    |=> first_cfg_ff == `FIRST_CFG_RST && second_cfg_ff == `SECOND_CFG_RST
        && logic_reset_ff && !rst_bits_ff[1])
    else $error("full soft reset did not restore registers");

  chk_logic_reset_keep: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    clk_en && rst_bits_ff == 2'h1
    |=> logic_reset_ff && $stable(first_cfg_ff) && $stable(second_cfg_ff))
    else $error("logic-only reset disturbed the registers");

  chk_crc_enable: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    clk_en && wr_first && !rst_bits_ff[1]
    |=> crc_check_en == $past(wr_req.data[`BIT_CRC_EN]))
    else $error("CRC checker enable did not follow the write");

  chk_auto_ack_gate: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    clk_en && !first_cfg_ff[`BIT_AUTO_ACK] |=> !remote_auto_ack)
    else $error("early acknowledge while disabled");

  chk_osc_fallback: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    clk_en && first_cfg_ff[`BIT_OSC_AUTO] && !pclk_sy_ff[1] && !logic_reset_ff
    |=> osc_select)
    else $error("no oscillator fallback without pixel clock");

  chk_edge_select: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    clk_en && wr_first && !rst_bits_ff[1]
    |=> pixel_edge_select == $past(wr_req.data[`BIT_EDGE_SEL]))
    else $error("edge select did not follow the write");

  chk_failsafe_level: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    clk_en && wr_second && !rst_bits_ff[1]
    |=> failsafe_low == $past(wr_req.data[`BIT_FAILSAFE]))
    else $error("failsafe level did not follow the write");

  chk_crc_clear_hold: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    crc_clear && !wr_second && !rst_bits_ff[1] |=> crc_clear)
    else $error("CRC clear bit dropped by itself");

  chk_compat_source: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    clk_en ##1 clk_en
    |-> legacy_compat_mode == ($past(second_cfg_ff[`BIT_COMPAT_SRC]) ?
        $past(second_cfg_ff[`BIT_COMPAT_REG]) : $past(mode_sy_ff[1])))
    else $error("compat mode taken from the wrong source");

  cov_full_reset: cover property (
    @(posedge ref_clk) disable iff (!arst_n) rst_bits_ff[1]);

  cov_osc_switch: cover property (
    @(posedge ref_clk) disable iff (!arst_n) $rose(osc_select));

endmodule

// ---- serializer_config_regs_end.sv ----
/*
  Holds no code; the register bank lives in serializer_config_regs.sv.
  Assumes nothing of its surroundings.
*/

// ---- test_serializer_config_regs.sv ----
/*
  Self-checking bench of the register bank: bus access, resets, controls.
  Assumes the design files and cfg_map.svh are compiled before it.
*/
`timescale 1ns/10ps
`include "cfg_map.svh"
module test_serializer_config_regs;
  logic            ref_clk, arst_n, scl, sda_m, mode_pin, pclk_ok, tick;
  logic            hit, pall, sda_oe, lrst, lr_seen, de_seen, so, ce;
  wire  [10:0]     ctl;
  logic [7:0]      rd;
  cfg_pkg::video_t vin, vout;
  int              failures, checked, pc;
  wire             sda_w = sda_m & ~sda_oe;
  typedef struct {logic [7:0] o, d, e;} row_t;
  row_t rows[5] = '{'{8'h03,8'hff,8'hfb}, '{8'h03,8'h00,8'h40},
    '{8'h04,8'hfc,8'hac}, '{8'h04,8'h00,8'h00}, '{8'h06,8'h5a,8'h00}};
  serializer_config_regs u_dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .clk_en(ce), .scl_in(scl), .sda_in(sda_w), .sda_out(so),
    .sda_oe(sda_oe), .dev_addr(7'h2a), .mode_sel_pin(mode_pin),
    .pclk_present(pclk_ok), .pix_tick(tick), .video_in(vin),
    .remote_target_hit(hit), .pass_all_en(pall), .video_out(vout),
    .crc_check_en(ctl[0]), .remote_auto_ack(ctl[1]),
    .pass_through_en(ctl[2]), .remote_auto_pd(ctl[3]),
    .osc_select(ctl[4]), .pixel_edge_select(ctl[5]),
    .failsafe_low(ctl[6]), .crc_clear(ctl[7]),
    .legacy_compat_mode(ctl[8]), .logic_reset(lrst));
  assign ctl[10:9] = 2'b00;
  //////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    pc <= (pc == 3) ? 0 : pc + 1;
    tick <= (pc == 3);
    if (lrst === 1'b1) lr_seen <= 1;
    if (vout.de === 1'b1) de_seen <= 1;
  end
  task automatic cy(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk(string nm, logic [10:0] e, logic [10:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bt(logic b, output logic r);
    sda_m <= b;
    cy(6);
    scl <= 1;
    cy(6);
    r = sda_w;
    scl <= 0;
    cy(1);
  endtask
  task automatic wb(logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bt(v[i], r);
    bt(1, r);
    chk("ack", 0, r);
  endtask
  task automatic rb(output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bt(1, v[i]);
    bt(1, r);
  endtask
  task automatic st();
    sda_m <= 1;
    cy(6);
    scl <= 1;
    cy(6);
    sda_m <= 0;
    cy(6);
    scl <= 0;
    cy(1);
  endtask
  task automatic sp();
    sda_m <= 0;
    cy(6);
    scl <= 1;
    cy(6);
    sda_m <= 1;
    cy(6);
  endtask
  task automatic wr(logic [7:0] o, logic [7:0] d);
    st(); wb(8'h54); wb(o); wb(d); sp();
  endtask
  task automatic rg(logic [7:0] o, output logic [7:0] d);
    st(); wb(8'h54); wb(o); st(); wb(8'h55); rb(d); sp();
  endtask
  task automatic print_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    #1ms;
    failures++;
    print_verdict();
  end
  initial begin
    {arst_n, hit, pall, mode_pin, tick, pc, lr_seen, de_seen} = 0;
    {scl, sda_m, pclk_ok, ce} = 4'hf;
    vin = '0;
    failures = 0;
    checked = 0;
    cy(16);
    arst_n <= 1;
    cy(4);
    chk("rst_ctl", 11'h041, ctl);
    rg(8'h03, rd); chk("first_rst", 8'hd2, rd);
    rg(8'h04, rd); chk("second_rst", 8'h80, rd);
    foreach (rows[i]) begin
      wr(rows[i].o, rows[i].d);
      rg(rows[i].o, rd); chk("row", rows[i].e, rd);
    end
    chk("sda_out", 0, so);
    wr(8'h03, 8'h89); cy(3); chk("cfg1_out", 11'h025, ctl);
    wr(8'h04, 8'h2c); cy(3); chk("cfg2_out", 11'h1a5, ctl);
    wr(8'h04, 8'h08); cy(3); chk("compat_off", 11'h000, ctl[8]);
    mode_pin <= 1;
    wr(8'h04, 8'h00); cy(4); chk("compat_pin", 11'h001, ctl[8]);
    wr(8'h03, 8'h22); hit <= 1; pclk_ok <= 0; cy(6);
    chk("aack_osc", 11'h012, ctl[4:0] & 5'h12);
    hit <= 0; pall <= 1; pclk_ok <= 1; cy(6);
    chk("aack_all", 11'h002, ctl[4:0] & 5'h12);
    ce <= 0; pclk_ok <= 0; cy(6); chk("freeze", 0, ctl[4]);
    ce <= 1; cy(6); chk("thaw", 1, ctl[4]); pclk_ok <= 1;
    wr(8'h03, 8'h10); de_seen <= 0;
    vin.de <= 1; cy(4); vin.de <= 0; cy(20);
    chk("short_pulse", 0, de_seen);
    vin <= 3'h7; cy(20); chk("long_pulse", 3'h7, vout);
    vin <= '0; wr(8'h03, 8'h00); cy(10); de_seen <= 0;
    vin.de <= 1; cy(4); vin.de <= 0; cy(10);
    chk("no_filter", 1, de_seen);
    lr_seen <= 0;
    wr(8'h01, 8'h81); rg(8'h03, rd); chk("keep_regs", 8'h40, rd);
    chk("pulse0", 1, lr_seen);
    rg(8'h01, rd); chk("self_clr0", 8'h80, rd);
    chk("auto_pd", 1, ctl[3]);
    lr_seen <= 0;
    wr(8'h01, 8'h02); rg(8'h03, rd); chk("full_rst", 8'hd2, rd);
    chk("pulse1", 1, lr_seen);
    rg(8'h01, rd); chk("self_clr1", 8'h00, rd);
    chk("full_ctl", 11'h141, ctl);
    print_verdict();
  end
endmodule

// ---- video_filter.sv ----
/*
  Synchronises the video control pins and rejects short pulses on them.
  Assumes pix_tick marks one pixel clock period in the ref_clk domain.
*/
`timescale 1ns/10ps
`include "cfg_map.svh"

module video_filter (
  input  wire logic            ref_clk,
  input  wire logic            arst_n,
  input  wire logic            clk_en,
  input  wire logic            sync_rst,
  input  wire logic            pix_tick,
  input  wire logic            en,
  input  wire cfg_pkg::video_t raw,
  output cfg_pkg::video_t      out
);

  cfg_pkg::video_t s1_ff;
  cfg_pkg::video_t s2_ff;
  cfg_pkg::video_t prev_ff;
  cfg_pkg::video_t out_ff;

  //////////////////////////////////////////////////////////////////////////
  // Two stage pin synchroniser
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_ff <= '0;
      s2_ff <= '0;
    end else if (clk_en) begin
      s1_ff <= raw;
      s2_ff <= s1_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Level passes after two equal pixel samples when enabled, at once when disabled
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_ff <= '0;
      out_ff  <= '0;
    end else if (clk_en) begin
      if (sync_rst) begin
        prev_ff <= '0;
        out_ff  <= '0;
      end else if (!en) begin
        prev_ff <= s2_ff;
        out_ff  <= s2_ff;
      end else if (pix_tick) begin
        prev_ff <= s2_ff;
        if (s2_ff == prev_ff) begin
          out_ff <= s2_ff;
        end
      end
    end
  end

  assign out = out_ff;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  chk_filter_short_pulse: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    clk_en && en && pix_tick && !sync_rst && (s2_ff != prev_ff)
    |=> out_ff == $past(out_ff))
    else $error("filter let a short pulse through");

  cov_filter_pass: cover property (
    @(posedge ref_clk) disable iff (!arst_n)
    clk_en && en && pix_tick && (out_ff != s2_ff) && (s2_ff == prev_ff));

endmodule
